// ==== core/tis_pkg.sv ====
// Purpose: Shared constants for the trap and interrupt sequencer
// Assumes: 32-bit AXI4-Lite register bus, 24-bit program addresses
// Notes: Byte offsets are aligned words
package tis_pkg;
    // ********************************
    // Register map
    // ********************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PRIO = 8'h04;
    localparam logic [7:0] OFS_SPLIMIT = 8'h08;
    localparam logic [7:0] OFS_IFLAG = 8'h0C;
    localparam logic [7:0] OFS_IENABLE = 8'h10;
    localparam logic [7:0] OFS_IPRIO = 8'h14;
    localparam logic [7:0] OFS_TRAPSTAT = 8'h18;
    localparam logic [7:0] OFS_RSTCTRL = 8'h1C;
    // ********************************
    // Fields and reset values
    // ********************************
    localparam int CTRL_OVF31_EN = 0;
    localparam int CTRL_OVF39_EN = 1;
    localparam int CTRL_ALT_TABLE = 15;
    localparam int RC_EXT = 0;
    localparam int RC_WDT = 1;
    localparam int RC_UNINIT_W = 2;
    localparam int RC_ILLEGAL = 3;
    localparam int RC_BROWNOUT = 4;
    localparam int RC_SWRESET = 5;
    localparam int RC_TRAP_CONFLICT = 15;
    localparam logic [31:0] IPRIO_RESET = 32'h4444_4444;
    localparam logic [15:0] SPLIMIT_RESET = 16'hFFFF;
    localparam int NUM_IRQ = 8;
    // ********************************
    // Priorities and vectors
    // ********************************
    localparam logic [3:0] PRIO_INT_MAX = 4'h7;
    localparam logic [3:0] LVL_MATH = 4'hB;
    localparam logic [3:0] LVL_HARD_MIN = 4'hC;
    localparam logic [15:0] STACK_FLOOR = 16'h0800;
    localparam logic [23:0] RESET_VECTOR = 24'h00_0000;
    localparam logic [23:0] PRI_TABLE_BASE = 24'h00_0004;
    localparam logic [23:0] ALT_TABLE_BASE = 24'h00_0084;
    localparam logic [5:0] SLOT_IRQ_BASE = 6'h08;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
    typedef enum logic [0:0] {
        SEQ_BOOT = 1'b0,
        SEQ_RUN = 1'b1
    } tis_seq_t;
endpackage : tis_pkg

// ==== core/tis_sequencer.sv ====
// Purpose: Trap and interrupt sequencer for a 16-bit signal controller core
// Assumes: One aclk edge per instruction cycle; core faults arrive as pulses
// Notes: Registers over AXI4-Lite; assertions sit beside the logic
// Operation
// - Any reset restarts fetch at address zero
// - Six error sources request a device reset
// - Flushed illegal opcodes never trap
// - Traps use levels eight to fifteen
// - Level seven blocks interrupts, not traps
// - Faulting instruction finishes before trap entry; hard traps enter once halted, without waiting for instr_done
// - Divide by zero aborts and traps
// - Enabled accumulator overflows raise math trap
// - Oversized shift amount raises math trap
// - Bad addresses and fetches raise address trap
// - Stack pointer outside limits raises stack trap
// - Oscillator failover raises oscillator trap
// - Simultaneous traps served by fixed priority
// - Levels eight to eleven are soft; math eleven
// - Levels twelve to fourteen: address, stack, oscillator
// - Hard trap halts execution until acknowledged
// - Lower hard trap conflict resets, sets flag
// - Flags sampled each cycle, enabled ones compared
// - Interrupt only above current priority level
// - Entry pushes PC and status, raises priority
// - Return pops PC and status, restores priority
// - Select bit switches to alternate vector table
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
module tis_sequencer
    import tis_pkg::*;
(
    input wire logic aclk, // Instruction clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [7:0] s_awaddr, // Write address
    input wire logic s_awvalid, // Write address valid
    output logic s_awready, // Write address ready
    input wire logic [31:0] s_wdata, // Write data
    input wire logic [3:0] s_wstrb, // Write byte enables
    input wire logic s_wvalid, // Write data valid
    output logic s_wready, // Write data ready
    output logic [1:0] s_bresp, // Write response
    output logic s_bvalid, // Write response valid
    input wire logic s_bready, // Write response ready
    input wire logic [7:0] s_araddr, // Read address
    input wire logic s_arvalid, // Read address valid
    output logic s_arready, // Read address ready
    output logic [31:0] s_rdata, // Read data
    output logic [1:0] s_rresp, // Read response
    output logic s_rvalid, // Read data valid
    input wire logic s_rready, // Read data ready
    input wire logic instr_done, // Current instruction completed
    input wire logic [23:0] cur_pc, // Return address of the next instruction
    input wire logic return_from_interrupt, // Return instruction executes
    input wire logic [7:0] popped_status, // Status low byte from the stack
    input wire logic hard_trap_ack, // Core acknowledges a hard trap
    input wire logic div_by_zero, // Divide with zero divisor
    input wire logic acc_ovf31, // Accumulator overflow out of bit 31
    input wire logic guard_unused, // Guard bits not in use
    input wire logic acc_ovf39, // Accumulator overflow out of bit 39
    input wire logic sat_disabled, // All saturation disabled
    input wire logic shift_too_big, // Shift amount above the maximum
    input wire logic misaligned_access, // Misaligned word access
    input wire logic unimpl_data_read, // Read of unimplemented data space
    input wire logic unimpl_prog_read, // Read of unimplemented program space
    input wire logic vector_fetch, // Instruction fetch from vector space
    input wire logic unimpl_branch, // Branch or execution at bad address
    input wire logic sp_load, // Stack pointer written
    input wire logic [15:0] sp_value, // New stack pointer value
    input wire logic osc_fail, // Fell back to internal RC source
    input wire logic ext_reset, // External reset event
    input wire logic watchdog_timeout, // Watchdog expired
    input wire logic uninit_w_pointer, // Uninitialised register as pointer
    input wire logic illegal_exec, // Unused opcode reached execute
    input wire logic illegal_flushed, // That opcode was flushed
    input wire logic brownout_reset, // Supply dip detected
    input wire logic sw_reset, // Software reset instruction
    input wire logic [NUM_IRQ-1:0] irq_event, // Peripheral interrupt events
    output logic reset_req, // Device reset request, one cycle
    output logic div_abort, // Abort the divide, one cycle
    output logic core_halt, // Halt code execution
    output logic fetch_valid, // Redirect fetch, one cycle
    output logic [23:0] fetch_addr, // Redirect target
    output logic push_valid, // Push frame, one cycle
    output logic [23:0] push_pc, // Pushed program counter
    output logic [7:0] push_status, // Pushed status low byte
    output logic [3:0] processor_priority_level // Current priority
);
    // ********************************
    // Helpers
    // ********************************
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic [23:0] vec_addr(input logic [5:0] slot, input logic alt);
        logic [23:0] base;
        base = alt ? ALT_TABLE_BASE : PRI_TABLE_BASE;
        return base + {17'h0, slot, 1'b0};
    endfunction : vec_addr

    tis_seq_t seq_q;
    logic [31:0] ctrl_q, prio_reg_q, iprio_q;
    logic [15:0] splimit_q, reset_control_reg_q;
    logic [NUM_IRQ-1:0] ifs_q, iec_q;
    logic [3:0] trap_pend_q, cpu_prio_q, hard_lvl_q;
    logic aw_have_q, w_have_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_go, halt_q;
    // ********************************
    // AXI4-Lite slave
    // ********************************
    assign wr_go = aw_have_q && w_have_q && !s_bvalid;

    function automatic logic mapped(input logic [7:0] a);
        return a[1:0] == 2'h0 && a <= OFS_RSTCTRL;
    endfunction : mapped

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_awready <= 1'b1;
            s_wready <= 1'b1;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_bvalid <= 1'b0;
            s_bresp <= AXI_OKAY;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_awaddr;
                s_awready <= 1'b0;
            end
            if (s_wvalid && s_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_wdata;
                w_strb_q <= s_wstrb;
                s_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp <= mapped(aw_addr_q) ? AXI_OKAY : AXI_SLVERR;
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
                s_awready <= 1'b1;
                s_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_arready <= 1'b1;
            s_rvalid <= 1'b0;
            s_rdata <= 32'h0000_0000;
            s_rresp <= AXI_OKAY;
        end else if (s_arvalid && s_arready) begin
            s_arready <= 1'b0;
            s_rvalid <= 1'b1;
            s_rresp <= mapped(s_araddr) ? AXI_OKAY : AXI_SLVERR;
            case (s_araddr)
                OFS_CTRL: s_rdata <= ctrl_q;
                OFS_PRIO: s_rdata <= {28'h0, cpu_prio_q};
                OFS_SPLIMIT: s_rdata <= {16'h0, splimit_q};
                OFS_IFLAG: s_rdata <= {24'h0, ifs_q};
                OFS_IENABLE: s_rdata <= {24'h0, iec_q};
                OFS_IPRIO: s_rdata <= iprio_q;
                OFS_TRAPSTAT: s_rdata <= {23'h0, halt_q, hard_lvl_q, trap_pend_q};
                OFS_RSTCTRL: s_rdata <= {16'h0, reset_control_reg_q};
                default: s_rdata <= 32'h0000_0000;
            endcase
        end else if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
            s_arready <= 1'b1;
        end
    end
    // ********************************
    // Plain control registers
    // ********************************
    logic [31:0] wr_merged;
    assign wr_merged = merge(32'h0000_0000, w_data_q, w_strb_q);
    logic [31:0] splimit_merged;
    assign splimit_merged = merge({16'h0, splimit_q}, w_data_q, w_strb_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= 32'h0000_0000;
            splimit_q <= SPLIMIT_RESET;
            iec_q <= '0;
            iprio_q <= IPRIO_RESET;
            prio_reg_q <= 32'h0000_0000;
        end else begin
            prio_reg_q <= 32'h0000_0000;
            if (wr_go) begin
                case (aw_addr_q)
                    OFS_CTRL: ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q) & 32'h0000_8003;
                    OFS_SPLIMIT: splimit_q <= splimit_merged[15:0];
                    OFS_IENABLE: iec_q <= wr_merged[NUM_IRQ-1:0];
                    OFS_IPRIO: iprio_q <= merge(iprio_q, w_data_q, w_strb_q) & 32'h7777_7777;
                    OFS_PRIO: prio_reg_q <= {28'h0, 1'b1, wr_merged[2:0]};
                    default: ;
                endcase
            end
        end
    end
    // ********************************
    // Interrupt request sampling
    // ********************************
    // Set wins over the write-one-to-clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ifs_q <= '0;
        end else begin
            ifs_q <= (ifs_q & ~((wr_go && aw_addr_q == OFS_IFLAG)
                     ? wr_merged[NUM_IRQ-1:0] : '0)) | irq_event;
        end
    end

    logic [NUM_IRQ-1:0] irq_req;
    logic [2:0] best_irq_prio, best_irq_src;
    logic irq_win;
    assign irq_req = ifs_q & iec_q;

    always_comb begin
        best_irq_prio = 3'h0;
        best_irq_src = 3'h0;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            // Lower source index wins ties: natural order
            if (irq_req[i] && iprio_q[4*i +: 3] >= best_irq_prio && iprio_q[4*i +: 3] != 3'h0) begin
                best_irq_prio = iprio_q[4*i +: 3];
                best_irq_src = i[2:0];
            end
        end
    end
    // Level seven or above admits no interrupt at all
    assign irq_win = {1'b0, best_irq_prio} > cpu_prio_q;
    // ********************************
    // Trap detection
    // ********************************
    logic ev_math, ev_addr, ev_stack, ev_osc, conflict, rst_any;
    logic [3:0] ev_traps, new_hard_lvl, top_trap_lvl;
    logic [1:0] top_trap_idx;
    logic trap_win;
    assign ev_math = div_by_zero
        || (acc_ovf31 && guard_unused && ctrl_q[CTRL_OVF31_EN])
        || (acc_ovf39 && sat_disabled && ctrl_q[CTRL_OVF39_EN])
        || shift_too_big;
    assign ev_addr = misaligned_access || unimpl_data_read || unimpl_prog_read
        || vector_fetch || unimpl_branch;
    assign ev_stack = sp_load && (sp_value > splimit_q || sp_value < STACK_FLOOR);
    assign ev_osc = osc_fail;
    assign ev_traps = {ev_osc, ev_stack, ev_addr, ev_math};
    // Index i carries level eleven plus i
    assign new_hard_lvl = ev_osc ? 4'hE : ev_stack ? 4'hD : ev_addr ? LVL_HARD_MIN : 4'h0;
    assign conflict = new_hard_lvl != 4'h0 && hard_lvl_q != 4'h0
        && new_hard_lvl < hard_lvl_q;
    assign top_trap_idx = trap_pend_q[3] ? 2'd3 : trap_pend_q[2] ? 2'd2 : trap_pend_q[1] ? 2'd1 : 2'd0;
    assign top_trap_lvl = LVL_MATH + {2'b00, top_trap_idx};
    assign trap_win = trap_pend_q != 4'h0 && top_trap_lvl > cpu_prio_q;
    assign rst_any = ext_reset || watchdog_timeout || uninit_w_pointer
        || (illegal_exec && !illegal_flushed)
        || brownout_reset || sw_reset || conflict;

    logic take_trap, take_irq, boundary;
    // Hard trap entry cannot wait for an instruction the core has halted
    assign boundary = seq_q == SEQ_RUN && !reset_req && (instr_done || halt_q);
    assign take_trap = boundary && trap_win;
    assign take_irq = boundary && !trap_win && irq_win && !halt_q;
    // ********************************
    // Reset causes and request
    // ********************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reset_control_reg_q <= 16'h0000;
            reset_req <= 1'b0;
        end else begin
            reset_req <= rst_any;
            reset_control_reg_q <= (reset_control_reg_q & ~((wr_go && aw_addr_q == OFS_RSTCTRL) ? wr_merged[15:0] : 16'h0))
                | {conflict, 9'h0, sw_reset, brownout_reset, illegal_exec && !illegal_flushed,
                   uninit_w_pointer, watchdog_timeout, ext_reset};
        end
    end
    // ********************************
    // Trap pending and hard trap state
    // ********************************
    logic [3:0] taken_mask;
    assign taken_mask = take_trap ? (4'h1 << top_trap_idx) : 4'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn || reset_req) begin
            trap_pend_q <= 4'h0;
            hard_lvl_q <= 4'h0;
            halt_q <= 1'b0;
            div_abort <= 1'b0;
        end else begin
            div_abort <= div_by_zero;
            trap_pend_q <= (trap_pend_q & ~taken_mask) | ev_traps;
            if (new_hard_lvl > hard_lvl_q) begin
                hard_lvl_q <= new_hard_lvl;
            end else if (return_from_interrupt && cpu_prio_q == hard_lvl_q) begin
                hard_lvl_q <= 4'h0;
            end
            if (new_hard_lvl != 4'h0) begin
                halt_q <= 1'b1;
            end else if (hard_trap_ack) begin
                halt_q <= 1'b0;
            end
        end
    end
    assign core_halt = halt_q;
    // ********************************
    // Vectoring, stacking, return
    // ********************************
    always_ff @(posedge aclk) begin
        if (!aresetn || reset_req) begin
            seq_q <= SEQ_BOOT;
            cpu_prio_q <= 4'h0;
            fetch_valid <= 1'b0;
            fetch_addr <= RESET_VECTOR;
            push_valid <= 1'b0;
            push_pc <= 24'h00_0000;
            push_status <= 8'h00;
        end else begin
            fetch_valid <= 1'b0;
            push_valid <= 1'b0;
            case (seq_q)
                SEQ_BOOT: begin
                    fetch_valid <= 1'b1;
                    fetch_addr <= RESET_VECTOR;
                    seq_q <= SEQ_RUN;
                end
                SEQ_RUN: begin
                    if (take_trap || take_irq) begin
                        push_valid <= 1'b1;
                        push_pc <= cur_pc;
                        push_status <= {cpu_prio_q, 4'h0};
                        fetch_valid <= 1'b1;
                        if (take_trap) begin
                            cpu_prio_q <= top_trap_lvl;
                            fetch_addr <= vec_addr({4'h0, 2'd3 - top_trap_idx} + 6'h1,
                                                   ctrl_q[CTRL_ALT_TABLE]);
                        end else begin
                            cpu_prio_q <= {1'b0, best_irq_prio};
                            fetch_addr <= vec_addr(SLOT_IRQ_BASE + {3'h0, best_irq_src},
                                                   ctrl_q[CTRL_ALT_TABLE]);
                        end
                    end else if (return_from_interrupt) begin
                        cpu_prio_q <= popped_status[7:4];
                    end else if (prio_reg_q[3]) begin
                        cpu_prio_q <= {1'b0, prio_reg_q[2:0]};
                    end
                end
                default: seq_q <= SEQ_BOOT;
            endcase
        end
    end
    assign processor_priority_level = cpu_prio_q;
    // ********************************
    // Checks
    // ********************************
    property p_boot_fetch;
        @(posedge aclk) $rose(aresetn) |=> fetch_valid && fetch_addr == RESET_VECTOR;
    endproperty
    a_boot_fetch: assert property (p_boot_fetch) else $error("no reset fetch");

    property p_flushed_quiet;
        @(posedge aclk) disable iff (!aresetn)
        illegal_exec && illegal_flushed && !(ext_reset || watchdog_timeout || uninit_w_pointer
        || brownout_reset || sw_reset || conflict) |=> !reset_req;
    endproperty
    a_flushed_quiet: assert property (p_flushed_quiet) else $error("flushed opcode reset");

    property p_trap_prio;
        @(posedge aclk) disable iff (!aresetn)
        take_trap |=> processor_priority_level[3] && push_valid;
    endproperty
    a_trap_prio: assert property (p_trap_prio) else $error("trap level wrong");

    property p_irq_gate;
        @(posedge aclk) disable iff (!aresetn)
        take_irq |-> {1'b0, best_irq_prio} > cpu_prio_q && cpu_prio_q < PRIO_INT_MAX;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt not above level");

    property p_div_abort;
        @(posedge aclk) disable iff (!aresetn || reset_req)
        div_by_zero |=> div_abort && trap_pend_q[0];
    endproperty
    a_div_abort: assert property (p_div_abort) else $error("divide not aborted");

    property p_stack_floor;
        @(posedge aclk) disable iff (!aresetn || reset_req)
        sp_load && sp_value < STACK_FLOOR |=> trap_pend_q[2];
    endproperty
    a_stack_floor: assert property (p_stack_floor) else $error("stack underflow missed");

    property p_conflict;
        @(posedge aclk) disable iff (!aresetn)
        conflict |=> reset_req && reset_control_reg_q[RC_TRAP_CONFLICT];
    endproperty
    a_conflict: assert property (p_conflict) else $error("conflict not reset");

    property p_halt;
        @(posedge aclk) disable iff (!aresetn || reset_req)
        core_halt && !hard_trap_ack && new_hard_lvl == 4'h0 |=> core_halt;
    endproperty
    a_halt: assert property (p_halt) else $error("halt dropped early");

    sequence s_ret;
        return_from_interrupt && !take_trap && !take_irq && seq_q == SEQ_RUN;
    endsequence
    property p_return;
        @(posedge aclk) disable iff (!aresetn || reset_req)
        s_ret |=> processor_priority_level == $past(popped_status[7:4]);
    endproperty
    a_return: assert property (p_return) else $error("priority not restored");
endmodule : tis_sequencer

// ==== verif/tis_core_model.sv ====
// Purpose: Core pipeline model facing the sequencer
// Assumes: One boundary a cycle, one in four when slow
// Notes: Hard trap acked four cycles into the halt
module tis_core_model (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset, active low
    input wire logic slow, // Long instructions
    input wire logic core_halt, // Halt request
    output logic instr_done, // Boundary pulse
    output logic hard_trap_ack // Ack pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] ph_q;
    logic [2:0] tmr_q;
    always_ff @(posedge aclk) begin
        ph_q <= aresetn ? ph_q + 2'h1 : 2'h0;
        instr_done <= aresetn && !core_halt && (!slow || ph_q == 2'h0);
    end
    // Late ack leaves the halt visible
    always_ff @(posedge aclk) begin
        tmr_q <= (aresetn && core_halt) ? tmr_q + 3'h1 : 3'h0;
        hard_trap_ack <= aresetn && core_halt && tmr_q == 3'h3;
    end
endmodule : tis_core_model

// ==== verif/tb_tis_sequencer.sv ====
// Purpose: Self-checking bench for the trap and interrupt sequencer
// Assumes: Core model drives boundaries and hard trap acks
// Notes: Fetches and pushes checked against queued notes
module tb_tis_sequencer;
    timeunit 1ns;
    timeprecision 1ns;
    import tis_pkg::*;
    logic aclk = 0, aresetn = 0, s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0;
    logic s_rready = 0, guard_unused = 1, sat_disabled = 1, slow = 0;
    logic [7:0] s_awaddr = 0, s_araddr = 0, popped_status = 0, irq_event = 0, push_status;
    logic [31:0] s_wdata = 0, s_rdata;
    logic [3:0] s_wstrb = 4'hF, processor_priority_level;
    logic [23:0] cur_pc = 0, fetch_addr, push_pc;
    logic [15:0] sp_value = 0;
    logic [18:0] flt = 0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, instr_done, hard_trap_ack;
    logic reset_req, div_abort, core_halt, fetch_valid, push_valid;
    logic [1:0] s_bresp, s_rresp;
    logic [23:0] fq[$];
    logic [7:0] pq[$];
    int miscompares = 0, n_compared = 0, cyc = 0, b, n;
    int srcs[11] = '{6, 10, 11, 18, 12, 13, 14, 15, 16, 17, 7};
    tis_sequencer dut (.*, .return_from_interrupt(flt[9]), .div_by_zero(flt[6]),
        .acc_ovf31(flt[10]), .acc_ovf39(flt[18]), .shift_too_big(flt[11]),
        .misaligned_access(flt[12]), .unimpl_data_read(flt[13]), .unimpl_prog_read(flt[14]),
        .vector_fetch(flt[15]), .unimpl_branch(flt[16]), .sp_load(flt[17]), .osc_fail(flt[7]),
        .ext_reset(flt[0]), .watchdog_timeout(flt[1]), .uninit_w_pointer(flt[2]),
        .illegal_exec(flt[3]), .illegal_flushed(flt[8]), .brownout_reset(flt[4]),
        .sw_reset(flt[5]));
    tis_core_model core (.*);
    always #25 aclk = ~aclk;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task finish_test;
        $display("Compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    task pm(input logic [18:0] m);
        flt <= m;
        @(posedge aclk);
        flt <= '0;
    endtask : pm
    task drain;
        while (fq.size() > 0) @(posedge aclk);
    endtask : drain
    task ret(input logic [7:0] s);
        popped_status <= s;
        pm(19'h200);
        @(posedge aclk);
        chk(processor_priority_level, s[7:4]);
    endtask : ret
    task axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        {s_awaddr, s_wdata, s_awvalid, s_wvalid, s_bready} <= {a, d, 3'h7};
        do @(posedge aclk); while (!(s_awready && s_wready));
        {s_awvalid, s_wvalid} <= 2'h0;
        do @(posedge aclk); while (!s_bvalid);
        s_bready <= 1'b0;
        chk(s_bresp, AXI_OKAY);
    endtask : axw
    task axr(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
             input logic [1:0] r);
        @(posedge aclk);
        {s_araddr, s_arvalid, s_rready} <= {a, 2'h3};
        do @(posedge aclk); while (!s_arready);
        s_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_rvalid);
        s_rready <= 1'b0;
        chk(s_rdata & m, e);
        chk(s_rresp, r);
    endtask : axr
    // Unexpected fetch or push compares against an impossible note
    always @(posedge aclk) begin
        cyc++;
        if (cyc > 5000) begin
            miscompares++;
            finish_test();
        end
        if (fetch_valid) chk(fetch_addr, fq.size() ? fq.pop_front() : 24'hFFFFFF);
        if (push_valid) chk({push_pc, push_status}, {cur_pc, pq.size() ? pq.pop_front() : 8'h1});
    end
    // ****************
    // Stimulus
    // ****************
    initial begin
        n = $urandom(32'hF44E);
        repeat (8) @(posedge aclk);
        fq.push_back(RESET_VECTOR);
        aresetn <= 1'b1;
        drain();
        for (b = 0; b < 6; b++) begin
            fq.push_back(RESET_VECTOR);
            pm(19'h1 << b);
            drain();
        end
        pm(19'h108);
        repeat (4) @(posedge aclk);
        axr(OFS_RSTCTRL, 32'h3F, 32'h3F, AXI_OKAY);
        axw(OFS_RSTCTRL, 32'hFFFF);
        axw(OFS_CTRL, 32'h3);
        foreach (srcs[i]) begin
            b = srcs[i];
            n = (b == 7) ? 1 : (b == 17) ? 2 : (b > 11 && b < 17) ? 3 : 4;
            slow <= 1'($urandom);
            cur_pc <= 24'($urandom);
            sp_value <= 16'($urandom_range(2047));
            fq.push_back(PRI_TABLE_BASE + 24'(2 * n));
            pq.push_back(8'h00);
            pm(19'h1 << b);
            if (b == 6) begin
                @(posedge aclk);
                chk(div_abort, 1);
            end
            drain();
            chk(processor_priority_level, 15 - n);
            if (n < 4) chk(core_halt, 1);
            while (core_halt) @(posedge aclk);
            ret(8'h00);
        end
        fq = '{PRI_TABLE_BASE + 24'h6, PRI_TABLE_BASE + 24'h8};
        pq = '{8'h00, 8'h00};
        pm(19'h1040);
        while (core_halt || fq.size() > 1) @(posedge aclk);
        ret(8'h00);
        drain();
        ret(8'h00);
        fq = '{PRI_TABLE_BASE + 24'h2, RESET_VECTOR};
        pq.push_back(8'h00);
        pm(19'h80);
        while (fq.size() > 1) @(posedge aclk);
        pm(19'h1000);
        drain();
        axr(OFS_RSTCTRL, 32'h8000, 32'h8000, AXI_OKAY);
        n = $urandom_range(7);
        axw(OFS_IENABLE, 32'hFF);
        axw(OFS_PRIO, 32'h7);
        irq_event <= 8'h1 << n;
        @(posedge aclk);
        irq_event <= 8'h0;
        repeat (6) @(posedge aclk);
        fq.push_back(PRI_TABLE_BASE + 24'h2);
        pq.push_back(8'h70);
        pm(19'h80);
        while (fq.size() > 0 || core_halt) @(posedge aclk);
        ret(8'h70);
        fq.push_back(PRI_TABLE_BASE + 24'(2 * (8 + n)));
        pq.push_back(8'h30);
        axw(OFS_PRIO, 32'h3);
        drain();
        chk(processor_priority_level, 4);
        axw(OFS_IFLAG, 32'h1 << n);
        ret(8'h30);
        fq.push_back(ALT_TABLE_BASE + 24'h8);
        pq.push_back(8'h30);
        axw(OFS_CTRL, 32'h8003);
        pm(19'h40);
        drain();
        ret(8'h30);
        axr(8'h20, '1, 0, AXI_SLVERR);
        finish_test();
    end
endmodule : tb_tis_sequencer
